// ---- sbcd_checker_props.sv ----
// sbcd_checker_props.sv: port assertions for the data-transfer decoder
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module sbcd_checker (
  // clock and reset
  input wire I_REF_CLK,
  input wire I_NRST,
  // inputs
  input wire [7:0] I_BYTE,
  input wire I_BYTE_VALID,
  input wire I_SHIFT_CNT_SRC,
  input wire I_FLAG_WE,
  input wire [15:0] I_FLAG_WDATA,
  // outputs
  input wire [15:0] O_FLAG_WORD,
  input wire O_DONE,
  input wire O_FOREIGN,
  input wire [4:0] O_OP,
  input wire O_WORD,
  input wire [2:0] O_REG,
  input wire O_REG_HIGH_BYTE,
  input wire O_RM_IS_REG,
  input wire [2:0] O_RM,
  input wire [2:0] O_BASE_REG,
  input wire O_BASE_EN,
  input wire [2:0] O_INDEX_REG,
  input wire O_INDEX_EN,
  input wire [15:0] O_IMM,
  input wire O_SHIFT_BY_CNT,
  input wire [1:0] O_STRDST_SEG
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  chk_flag_spare_zero: assert property ((O_FLAG_WORD & 16'hf02a) == 16'h0000)
    else $error("flag word spare bits set");
  chk_flag_write_mask: assert property (I_FLAG_WE |=>
    O_FLAG_WORD == ($past(I_FLAG_WDATA) & 16'h0fd5)) else $error("flag write wrong");
  chk_shift_count_src: assert property (1'b1 |=>
    O_SHIFT_BY_CNT == $past(I_SHIFT_CNT_SRC)) else $error("shift count source wrong");
  chk_strdst_extra_seg: assert property (O_STRDST_SEG == 2'h0)
    else $error("string destination segment not extra");
  chk_byte_reg_half: assert property (O_DONE && O_OP == 5'h03 |->
    O_REG_HIGH_BYTE == (!O_WORD && O_REG[2])) else $error("byte register half wrong");
  chk_rm_reg_noaddr: assert property (O_DONE && O_RM_IS_REG |->
    !O_BASE_EN && !O_INDEX_EN) else $error("register operand formed an address");
  chk_ea_base_index: assert property (O_DONE && O_OP == 5'h01 &&
    !O_RM_IS_REG && !O_RM[2] |-> O_BASE_EN && O_INDEX_EN &&
    O_BASE_REG == (O_RM[1] ? 3'h5 : 3'h3) && O_INDEX_REG == (O_RM[0] ? 3'h7 : 3'h6))
    else $error("base or index selection wrong");
  chk_pushf_last_byte: assert property (O_DONE && O_OP == 5'h19 |->
    $past(I_BYTE_VALID) && $past(I_BYTE) == 8'h9c) else $error("flag push without its opcode");
  chk_imm_last_byte: assert property (O_DONE && O_OP == 5'h03 |-> (O_WORD ?
    O_IMM[15:8] == $past(I_BYTE) : O_IMM == {{8{O_IMM[7]}}, $past(I_BYTE)}))
    else $error("immediate operand wrong");
  cov_mov_rm: cover property (O_DONE && O_OP == 5'h01);
  cov_foreign: cover property (O_FOREIGN);
  cov_flag_write: cover property (I_FLAG_WE);
endmodule // sbcd_checker

bind sbcd_decoder sbcd_checker u_checker (.I_REF_CLK, .I_NRST, .I_BYTE, .I_BYTE_VALID,
  .I_SHIFT_CNT_SRC, .I_FLAG_WE, .I_FLAG_WDATA, .O_FLAG_WORD, .O_DONE, .O_FOREIGN, .O_OP,
  .O_WORD, .O_REG, .O_REG_HIGH_BYTE, .O_RM_IS_REG, .O_RM, .O_BASE_REG, .O_BASE_EN,
  .O_INDEX_REG, .O_INDEX_EN, .O_IMM, .O_SHIFT_BY_CNT, .O_STRDST_SEG);

// ---- sbcd_consts.vh ----
// sbcd_consts.vh: constants for the data-transfer instruction decoder
// assumes inclusion by bare name from the decoder module
`ifndef SBCD_CONSTS_VH
`define SBCD_CONSTS_VH
// flag word bit positions
`define SBCD_FLAG_CARRY 0
`define SBCD_FLAG_PARITY 2
`define SBCD_FLAG_AUX 4
`define SBCD_FLAG_ZERO 6
`define SBCD_FLAG_SIGN 7
`define SBCD_FLAG_TRAP 8
`define SBCD_FLAG_INTEN 9
`define SBCD_FLAG_DIR 10
`define SBCD_FLAG_OVF 11
`define SBCD_FLAG_RESET 16'h0000
`define SBCD_FLAG_MASK 16'h0fd5
// segment codes
`define SBCD_SEG_EXTRA 2'h0
`define SBCD_SEG_CODE 2'h1
`define SBCD_SEG_STACK 2'h2
`define SBCD_SEG_DATA 2'h3
// word register codes
`define SBCD_REG_ACC 3'h0
`define SBCD_REG_CNT 3'h1
`define SBCD_REG_DAT 3'h2
`define SBCD_REG_BASE 3'h3
`define SBCD_REG_SP 3'h4
`define SBCD_REG_BP 3'h5
`define SBCD_REG_SRC 3'h6
`define SBCD_REG_DST 3'h7
// operation codes on o_OP
`define SBCD_OP_NONE 5'h00
`define SBCD_OP_MOV_RM 5'h01
`define SBCD_OP_MOV_IMM_RM 5'h02
`define SBCD_OP_MOV_IMM_REG 5'h03
`define SBCD_OP_LOAD_ACC 5'h04
`define SBCD_OP_STORE_ACC 5'h05
`define SBCD_OP_MOV_TO_SEG 5'h06
`define SBCD_OP_MOV_FROM_SEG 5'h07
`define SBCD_OP_PUSH_RM 5'h08
`define SBCD_OP_PUSH_REG 5'h09
`define SBCD_OP_PUSH_SEG 5'h0a
`define SBCD_OP_POP_RM 5'h0b
`define SBCD_OP_POP_REG 5'h0c
`define SBCD_OP_POP_SEG 5'h0d
`define SBCD_OP_XCHG_ACC 5'h0e
`define SBCD_OP_IN_FIX 5'h0f
`define SBCD_OP_IN_VAR 5'h10
`define SBCD_OP_OUT_FIX 5'h11
`define SBCD_OP_OUT_VAR 5'h12
`define SBCD_OP_LEA 5'h13
`define SBCD_OP_LDS 5'h14
`define SBCD_OP_LES 5'h15
`define SBCD_OP_XLAT 5'h16
`define SBCD_OP_LAHF 5'h17
`define SBCD_OP_SAHF 5'h18
`define SBCD_OP_PUSHF 5'h19
`define SBCD_OP_POPF 5'h1a
`endif

// ---- sbcd_decoder.v ----
// sbcd_decoder.v: decoder for the data-transfer group of a 16-bit cpu
// assumes a fetch unit offering one byte per cycle with valid/ready
`timescale 1ns/1ps
`include "sbcd_consts.vh"

// Summary of operation
// - flag word holds nine flags at fixed bits
// - width bit one means word, zero byte
// - sign-width 01 takes two immediate bytes
// - sign-width 10 sign-extends one immediate byte
// - shift count one, or count register when set
// - segment prefix redirects data segment defaults
// - no prefix on fetch or string destination
// - decode word register and segment codes
// - byte register codes select low/high halves
// - mode field sets displacement size or register
// - mode 00 rm 110 uses direct address
// - decode the three move forms
// - decode accumulator load/store with address bytes
// - decode moves to and from segment registers
// - decode three push forms
// - decode three pop forms
// - decode exchange and port input forms
// - decode port output forms
// - decode effective address and pointer loads
// - decode translate and flag transfer opcodes
module sbcd_decoder (
  // clock and reset
  input wire I_REF_CLK,
  input wire I_NRST,
  // instruction byte stream
  input wire [7:0] I_BYTE,
  input wire I_BYTE_VALID,
  output wire O_BYTE_READY,
  // shift opcode hint and flag word access
  input wire I_SHIFT_CNT_SRC,
  input wire I_FLAG_WE,
  input wire [15:0] I_FLAG_WDATA,
  output wire [15:0] O_FLAG_WORD,
  // decoded instruction
  output reg O_DONE,
  output reg O_FOREIGN,
  output reg [7:0] O_FOREIGN_OPCODE,
  output reg [4:0] O_OP,
  output reg O_WORD,
  output reg O_REG_IS_DEST,
  output reg [2:0] O_REG,
  output reg O_REG_HIGH_BYTE,
  output reg [1:0] O_SEG,
  output reg O_RM_IS_REG,
  output reg [2:0] O_RM,
  output reg [2:0] O_BASE_REG,
  output reg O_BASE_EN,
  output reg [2:0] O_INDEX_REG,
  output reg O_INDEX_EN,
  output reg [15:0] O_DISP,
  output reg [15:0] O_IMM,
  output reg O_SHIFT_BY_CNT,
  output reg [1:0] O_DATA_SEG,
  output reg [1:0] O_STRDST_SEG
);

  localparam [2:0] ST_OPC = 3'h0;
  localparam [2:0] ST_MODRM = 3'h1;
  localparam [2:0] ST_DLO = 3'h2;
  localparam [2:0] ST_DHI = 3'h3;
  localparam [2:0] ST_ILO = 3'h4;
  localparam [2:0] ST_IHI = 3'h5;

  reg [2:0] st_q;
  reg [15:0] flag_q;
  reg [7:0] opc_q;
  reg [1:0] mode_q;
  reg [2:0] rm_q;
  reg [2:0] regf_q;
  reg [1:0] ovr_q;
  reg ovr_en_q;
  reg [1:0] disp_n_q;
  reg [1:0] imm_n_q;
  reg [15:0] disp_q;
  reg [15:0] imm_q;

  // class lookup for the first byte: op, needs modrm, immediate bytes, address bytes
  function [4:0] op_of;
    input [7:0] b;
    begin
      casez (b)
        8'b100010??: op_of = `SBCD_OP_MOV_RM;
        8'b1100011?: op_of = `SBCD_OP_MOV_IMM_RM;
        8'b1011????: op_of = `SBCD_OP_MOV_IMM_REG;
        8'b1010000?: op_of = `SBCD_OP_LOAD_ACC;
        8'b1010001?: op_of = `SBCD_OP_STORE_ACC;
        8'b10001110: op_of = `SBCD_OP_MOV_TO_SEG;
        8'b10001100: op_of = `SBCD_OP_MOV_FROM_SEG;
        8'b11111111: op_of = `SBCD_OP_PUSH_RM;
        8'b01010???: op_of = `SBCD_OP_PUSH_REG;
        8'b000??110: op_of = `SBCD_OP_PUSH_SEG;
        8'b10001111: op_of = `SBCD_OP_POP_RM;
        8'b01011???: op_of = `SBCD_OP_POP_REG;
        8'b000??111: op_of = `SBCD_OP_POP_SEG;
        8'b10010???: op_of = `SBCD_OP_XCHG_ACC;
        8'b1110010?: op_of = `SBCD_OP_IN_FIX;
        8'b1110110?: op_of = `SBCD_OP_IN_VAR;
        8'b1110011?: op_of = `SBCD_OP_OUT_FIX;
        8'b1110111?: op_of = `SBCD_OP_OUT_VAR;
        8'b10001101: op_of = `SBCD_OP_LEA;
        8'b11000101: op_of = `SBCD_OP_LDS;
        8'b11000100: op_of = `SBCD_OP_LES;
        8'b11010111: op_of = `SBCD_OP_XLAT;
        8'b10011111: op_of = `SBCD_OP_LAHF;
        8'b10011110: op_of = `SBCD_OP_SAHF;
        8'b10011100: op_of = `SBCD_OP_PUSHF;
        8'b10011101: op_of = `SBCD_OP_POPF;
        default: op_of = `SBCD_OP_NONE;
      endcase
    end
  endfunction

  function has_modrm;
    input [4:0] op;
    begin
      case (op)
        `SBCD_OP_MOV_RM, `SBCD_OP_MOV_IMM_RM, `SBCD_OP_MOV_TO_SEG, `SBCD_OP_MOV_FROM_SEG,
        `SBCD_OP_PUSH_RM, `SBCD_OP_POP_RM, `SBCD_OP_LEA, `SBCD_OP_LDS,
        `SBCD_OP_LES: has_modrm = 1'b1;
        default: has_modrm = 1'b0;
      endcase
    end
  endfunction

  // immediate/port/address byte count; sign-width bits matter only for imm forms
  function [1:0] imm_bytes;
    input [4:0] op;
    input [7:0] b;
    begin
      case (op)
        `SBCD_OP_MOV_IMM_RM: imm_bytes = b[0] ? 2'd2 : 2'd1;
        `SBCD_OP_MOV_IMM_REG: imm_bytes = b[3] ? 2'd2 : 2'd1;
        `SBCD_OP_LOAD_ACC, `SBCD_OP_STORE_ACC: imm_bytes = 2'd2;
        `SBCD_OP_IN_FIX, `SBCD_OP_OUT_FIX: imm_bytes = 2'd1;
        default: imm_bytes = 2'd0;
      endcase
    end
  endfunction

  function [1:0] disp_bytes;
    input [1:0] mode;
    input [2:0] rm;
    begin
      case (mode)
        2'b00: disp_bytes = (rm == 3'b110) ? 2'd2 : 2'd0;
        2'b01: disp_bytes = 2'd1;
        2'b10: disp_bytes = 2'd2;
        default: disp_bytes = 2'd0;
      endcase
    end
  endfunction

  wire take = I_BYTE_VALID & O_BYTE_READY;
  wire [4:0] op_now = op_of(I_BYTE);
  wire is_prefix = (I_BYTE[7:5] == 3'b001) && (I_BYTE[2:0] == 3'b110);
  wire [1:0] imm_now = imm_bytes(op_now, I_BYTE);
  wire [1:0] disp_now = disp_bytes(I_BYTE[7:6], I_BYTE[2:0]);
  // the modrm byte is still on the bus when it completes an instruction
  wire [1:0] mode_fin = (st_q == ST_MODRM) ? I_BYTE[7:6] : mode_q;
  wire [2:0] rm_fin = (st_q == ST_MODRM) ? I_BYTE[2:0] : rm_q;
  wire modrm_last = (st_q == ST_MODRM) && (disp_now == 2'd0) && (imm_n_q == 2'd0);
  wire done_evt = take && (modrm_last ||
                  (st_q == ST_DLO && disp_n_q == 2'd1 && imm_n_q == 2'd0) ||
                  (st_q == ST_DHI && imm_n_q == 2'd0) ||
                  (st_q == ST_ILO && imm_n_q == 2'd1) || st_q == ST_IHI);
  wire [15:0] imm_fin = (st_q == ST_IHI) ? {I_BYTE, imm_q[7:0]} :
                        (st_q == ST_ILO) ? {{8{I_BYTE[7]}}, I_BYTE} : imm_q;
  wire [15:0] disp_fin = (st_q == ST_DHI) ? {I_BYTE, disp_q[7:0]} :
                         (st_q == ST_DLO) ? {{8{I_BYTE[7]}}, I_BYTE} : disp_q;

  // decoder accepts a byte every cycle; it never stalls the fetch unit
  assign O_BYTE_READY = 1'b1;
  assign O_FLAG_WORD = flag_q & `SBCD_FLAG_MASK;

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      flag_q <= `SBCD_FLAG_RESET;
    end else if (I_FLAG_WE) begin
      flag_q <= I_FLAG_WDATA & `SBCD_FLAG_MASK;
    end
  end

  // finish an instruction: publish fields decoded so far
  task finish;
    input [15:0] imm_v;
    input [15:0] disp_v;
    reg [4:0] op;
    begin
      op = op_of(opc_q);
      O_DONE <= 1'b1;
      O_OP <= op;
      O_IMM <= imm_v;
      O_DISP <= disp_v;
      O_RM_IS_REG <= (mode_fin == 2'b11);
      O_RM <= rm_fin;
      // direct address: no base or index at all
      O_BASE_EN <= (mode_fin != 2'b11) && !(mode_fin == 2'b00 && rm_fin == 3'b110) &&
                   (rm_fin[2:1] != 2'b10);
      O_BASE_REG <= (rm_fin == 3'b111 || rm_fin[2:1] == 2'b00) ?
                    `SBCD_REG_BASE : `SBCD_REG_BP;
      O_INDEX_EN <= (mode_fin != 2'b11) &&
                    (rm_fin[2] == 1'b0 || rm_fin[2:1] == 2'b10);
      O_INDEX_REG <= rm_fin[0] ? `SBCD_REG_DST : `SBCD_REG_SRC;
      // bp-based forms default to stack, as do register operands with rm 01x or 110; others to data
      if (ovr_en_q)
        O_DATA_SEG <= ovr_q;
      else if (rm_fin[2:1] == 2'b01 || (mode_fin != 2'b00 && rm_fin == 3'b110))
        O_DATA_SEG <= `SBCD_SEG_STACK;
      else
        O_DATA_SEG <= `SBCD_SEG_DATA;
      O_STRDST_SEG <= `SBCD_SEG_EXTRA;
    end
  endtask

  always @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      st_q <= ST_OPC;
      opc_q <= 8'h00;
      mode_q <= 2'b11;
      rm_q <= 3'h0;
      regf_q <= 3'h0;
      ovr_q <= `SBCD_SEG_DATA;
      ovr_en_q <= 1'b0;
      disp_n_q <= 2'd0;
      imm_n_q <= 2'd0;
      disp_q <= 16'h0000;
      imm_q <= 16'h0000;
      O_DONE <= 1'b0;
      O_FOREIGN <= 1'b0;
      O_FOREIGN_OPCODE <= 8'h00;
      O_OP <= `SBCD_OP_NONE;
      O_WORD <= 1'b0;
      O_REG_IS_DEST <= 1'b0;
      O_REG <= 3'h0;
      O_REG_HIGH_BYTE <= 1'b0;
      O_SEG <= `SBCD_SEG_DATA;
      O_RM_IS_REG <= 1'b0;
      O_RM <= 3'h0;
      O_BASE_REG <= 3'h0;
      O_BASE_EN <= 1'b0;
      O_INDEX_REG <= 3'h0;
      O_INDEX_EN <= 1'b0;
      O_DISP <= 16'h0000;
      O_IMM <= 16'h0000;
      O_SHIFT_BY_CNT <= 1'b0;
      O_DATA_SEG <= `SBCD_SEG_DATA;
      O_STRDST_SEG <= `SBCD_SEG_EXTRA;
    end else begin
      O_DONE <= 1'b0;
      O_FOREIGN <= 1'b0;
      O_SHIFT_BY_CNT <= I_SHIFT_CNT_SRC;
      if (take) begin
        case (st_q)
          ST_OPC: begin
            if (is_prefix) begin
              ovr_en_q <= 1'b1;
              ovr_q <= I_BYTE[4:3];
            end else if (op_now == `SBCD_OP_NONE) begin
              O_FOREIGN <= 1'b1;
              O_FOREIGN_OPCODE <= I_BYTE;
              ovr_en_q <= 1'b0;
            end else begin
              opc_q <= I_BYTE;
              mode_q <= 2'b11;
              rm_q <= 3'h0;
              imm_n_q <= imm_now;
              imm_q <= 16'h0000;
              disp_q <= 16'h0000;
              O_WORD <= (op_now == `SBCD_OP_MOV_IMM_REG) ? I_BYTE[3] : I_BYTE[0];
              O_REG_IS_DEST <= I_BYTE[1];
              // register in low bits for short forms
              O_REG <= I_BYTE[2:0];
              O_REG_HIGH_BYTE <= (op_now == `SBCD_OP_MOV_IMM_REG) && !I_BYTE[3] &&
                                 I_BYTE[2];
              O_SEG <= I_BYTE[4:3];
              if (has_modrm(op_now))
                st_q <= ST_MODRM;
              else if (imm_now != 2'd0)
                st_q <= ST_ILO;
              else begin
                st_q <= ST_OPC;
                O_DONE <= 1'b1;
                O_OP <= op_now;
                O_RM_IS_REG <= 1'b1;
                O_BASE_EN <= 1'b0;
                O_INDEX_EN <= 1'b0;
                O_DATA_SEG <= ovr_en_q ? ovr_q : `SBCD_SEG_DATA;
                O_STRDST_SEG <= `SBCD_SEG_EXTRA;
                ovr_en_q <= 1'b0;
              end
            end
          end
          ST_MODRM: begin
            mode_q <= I_BYTE[7:6];
            rm_q <= I_BYTE[2:0];
            regf_q <= I_BYTE[5:3];
            O_REG <= I_BYTE[5:3];
            O_SEG <= I_BYTE[4:3];
            O_REG_HIGH_BYTE <= !opc_q[0] && I_BYTE[5];
            disp_n_q <= disp_now;
            if (disp_now != 2'd0)
              st_q <= ST_DLO;
            else if (imm_n_q != 2'd0)
              st_q <= ST_ILO;
            else
              st_q <= ST_OPC;
          end
          ST_DLO: begin
            disp_q <= {{8{I_BYTE[7]}}, I_BYTE};
            if (disp_n_q == 2'd2)
              st_q <= ST_DHI;
            else if (imm_n_q != 2'd0)
              st_q <= ST_ILO;
            else
              st_q <= ST_OPC;
          end
          ST_DHI: begin
            disp_q <= {I_BYTE, disp_q[7:0]};
            st_q <= (imm_n_q != 2'd0) ? ST_ILO : ST_OPC;
          end
          ST_ILO: begin
            // one byte sign-extends (sw=10 style); two bytes form a word
            imm_q <= {{8{I_BYTE[7]}}, I_BYTE};
            st_q <= (imm_n_q == 2'd2) ? ST_IHI : ST_OPC;
          end
          ST_IHI: begin
            imm_q <= {I_BYTE, imm_q[7:0]};
            st_q <= ST_OPC;
          end
          default: st_q <= ST_OPC;
        endcase
      end
      // the prefix is spent once the instruction it qualifies completes
      if (done_evt) begin
        ovr_en_q <= 1'b0;
        finish(imm_fin, disp_fin);
      end
    end
  end

endmodule // sbcd_decoder

// ---- sbcd_fetch_model.sv ----
// sbcd_fetch_model.sv: fetch unit offering queued instruction bytes
// assumes the decoder samples valid/ready on the rising edge
`timescale 1ns/1ps
module sbcd_fetch_model (
  // clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid
);
  logic [7:0] q [$];
  logic slow = 1'b0;
  logic took = 1'b0;
  initial o_data = 8'h00;
  initial o_valid = 1'b0;
  always @(posedge i_clk) took <= o_valid && i_ready;
  // a byte holds until taken; slow mode idles one cycle between bytes
  always @(negedge i_clk) begin
    if (o_valid && !took) begin
    end else if (q.size() != 0 && !(slow && o_valid)) begin
      o_data <= q.pop_front();
      o_valid <= 1'b1;
    end else begin
      // idle bus shows inverted data so stale bytes never look valid
      o_valid <= 1'b0;
      o_data <= ~o_data;
    end
  end
endmodule // sbcd_fetch_model

// ---- sbcd_testbench.sv ----
// sbcd_testbench.sv: decodes instruction sequences and checks fields
// assumes sbcd_decoder, sbcd_fetch_model and sbcd_consts.vh on the path
`timescale 1ns/1ps
`include "sbcd_consts.vh"
module testbench;
  logic I_REF_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic I_SHIFT_CNT_SRC = 1'b0;
  logic I_FLAG_WE = 1'b0;
  logic [15:0] I_FLAG_WDATA = 16'h0000;
  logic [7:0] I_BYTE, O_FOREIGN_OPCODE;
  logic I_BYTE_VALID, O_BYTE_READY, O_DONE, O_FOREIGN, O_WORD, O_REG_IS_DEST, O_REG_HIGH_BYTE;
  logic O_RM_IS_REG, O_BASE_EN, O_INDEX_EN, O_SHIFT_BY_CNT;
  logic [15:0] O_FLAG_WORD, O_DISP, O_IMM;
  logic [4:0] O_OP;
  logic [2:0] O_REG, O_RM, O_BASE_REG, O_INDEX_REG;
  logic [1:0] O_SEG, O_DATA_SEG, O_STRDST_SEG;
  int fail_count = 0;
  int n_checks = 0;
  int i;
  // entry: op, byte count, bytes first-to-last
  localparam logic [79:0] TAB [20] = '{{8'h16, 8'd1, 64'hd7}, {8'h17, 8'd1, 64'h9f},
    {8'h18, 8'd1, 64'h9e}, {8'h19, 8'd1, 64'h9c}, {8'h1a, 8'd1, 64'h9d},
    {8'h0c, 8'd1, 64'h5b}, {8'h0d, 8'd1, 64'h1f}, {8'h0e, 8'd1, 64'h93},
    {8'h10, 8'd1, 64'hec}, {8'h12, 8'd1, 64'hee}, {8'h0f, 8'd2, 64'he460},
    {8'h11, 8'd2, 64'he661}, {8'h04, 8'd3, 64'ha13412}, {8'h05, 8'd3, 64'ha33412},
    {8'h07, 8'd2, 64'h8cc0}, {8'h08, 8'd4, 64'hff363412}, {8'h0b, 8'd4, 64'h8f063412},
    {8'h02, 8'd6, 64'hc70634127856}, {8'h13, 8'd2, 64'h8d07}, {8'h14, 8'd2, 64'hc507}};
  always #10 I_REF_CLK = ~I_REF_CLK;
  sbcd_fetch_model u_fetch (.i_clk(I_REF_CLK), .i_ready(O_BYTE_READY), .o_data(I_BYTE),
    .o_valid(I_BYTE_VALID));
  sbcd_decoder DUT (.I_REF_CLK, .I_NRST, .I_BYTE, .I_BYTE_VALID, .O_BYTE_READY,
    .I_SHIFT_CNT_SRC, .I_FLAG_WE, .I_FLAG_WDATA, .O_FLAG_WORD, .O_DONE, .O_FOREIGN,
    .O_FOREIGN_OPCODE, .O_OP, .O_WORD, .O_REG_IS_DEST, .O_REG, .O_REG_HIGH_BYTE, .O_SEG,
    .O_RM_IS_REG, .O_RM, .O_BASE_REG, .O_BASE_EN, .O_INDEX_REG, .O_INDEX_EN, .O_DISP,
    .O_IMM, .O_SHIFT_BY_CNT, .O_DATA_SEG, .O_STRDST_SEG);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // queue the bytes, then wait bounded for the decode pulse
  task automatic issue(input logic [63:0] b, input int n);
    int k;
    k = 0;
    for (int j = 0; j < n; j++) u_fetch.q.push_back(b[8 * (n - 1 - j) +: 8]);
    do begin
      @(posedge I_REF_CLK);
      #1;
      k++;
    end while (O_DONE !== 1'b1 && O_FOREIGN !== 1'b1 && k < 40);
    chk("decode pulse", 16'h1, {15'h0, O_DONE | O_FOREIGN});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude;
  end
  initial begin
    repeat (5) @(negedge I_REF_CLK);
    I_NRST = 1'b1;
    chk("ready", 16'h1, {15'h0, O_BYTE_READY});
    chk("data seg", 16'h3, {14'h0, O_DATA_SEG});
    chk("flags", 16'h0, O_FLAG_WORD);
    I_FLAG_WE = 1'b1;
    I_FLAG_WDATA = 16'hffff;
    @(negedge I_REF_CLK);
    I_FLAG_WE = 1'b0;
    @(negedge I_REF_CLK);
    chk("flags", 16'h0fd5, O_FLAG_WORD);
    for (i = 0; i < 2; i++) begin
      I_SHIFT_CNT_SRC = ~i[0];
      @(negedge I_REF_CLK);
      chk("shift", {15'h0, ~i[0]}, {15'h0, O_SHIFT_BY_CNT});
    end
    u_fetch.slow = 1'b1;
    issue(64'hb83412, 3);
    chk("imm", 16'h1234, O_IMM);
    chk("word", 16'h1, {15'h0, O_WORD});
    issue(64'h8b063412, 4);
    chk("disp", 16'h1234, O_DISP);
    chk("addr en", 16'h0, {14'h0, O_BASE_EN, O_INDEX_EN});
    u_fetch.slow = 1'b0;
    for (i = 0; i < 8; i++) begin
      issue({48'h0, 5'h16, i[2:0], 8'h80}, 2);
      chk("byte reg", {12'h0, i[2], i[2:0]}, {12'h0, O_REG_HIGH_BYTE, O_REG});
      chk("byte imm", 16'hff80, O_IMM);
      issue({56'h0, 5'h0a, i[2:0]}, 1);
      chk("push reg", {8'h09, 5'h0, i[2:0]}, {3'h0, O_OP, 5'h0, O_REG});
      issue({56'h0, 3'h0, i[1:0], 3'h6}, 1);
      chk("push seg", {8'h0a, 6'h0, i[1:0]}, {3'h0, O_OP, 6'h0, O_SEG});
    end
    issue(64'h8b40fe, 3);
    chk("mov dest", 16'h0103, {3'h0, O_OP, 6'h0, O_REG_IS_DEST, O_WORD});
    chk("disp8", 16'hfffe, O_DISP);
    chk("ea", 16'h1316, {3'h0, O_BASE_EN, 1'b0, O_BASE_REG, 3'h0, O_INDEX_EN, 1'b0,
      O_INDEX_REG});
    issue(64'h8b07, 2);
    chk("ea no disp", 16'h0103, {3'h0, O_RM_IS_REG, 3'h0, O_BASE_EN, 3'h0, O_INDEX_EN, 1'b0,
      O_BASE_REG});
    issue(64'h89d8, 2);
    chk("rm reg", 16'h10, {11'h0, O_RM_IS_REG, 3'h0, O_REG_IS_DEST});
    issue(64'h8b4610, 3);
    chk("bp seg", 16'h2, {14'h0, O_DATA_SEG});
    chk("rm", 16'h6, {13'h0, O_RM});
    issue(64'h268b4610, 4);
    chk("prefix seg", 16'h0, {12'h0, O_DATA_SEG, O_STRDST_SEG});
    issue(64'h8ed8, 2);
    chk("to seg", 16'h0603, {3'h0, O_OP, 6'h0, O_SEG});
    for (i = 0; i < 20; i++) begin
      issue(TAB[i][63:0], int'(TAB[i][71:64]));
      chk("table op", {8'h0, TAB[i][79:72]}, {11'h0, O_OP});
    end
    issue(64'h37, 1);
    chk("foreign", 16'h0137, {7'h0, O_FOREIGN, O_FOREIGN_OPCODE});
    conclude;
  end
endmodule // testbench
